// file: lpt_top.sv
// Purpose : low power timer control, prescaler, glitch filter and counter
// Assumes : APB slave on clk_in; clock sources and pulse pins are asynchronous
// Notes   : zero wait states; read data is captured in the setup cycle
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lpt_params.svh"
module lpt_top #(
  parameter int CNT_W = 16,
  parameter int NSRC  = 4,
  parameter int NPIN  = 4
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // apb slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [`LPT_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // asynchronous prescaler clock sources and pulse pins
  input  wire logic [NSRC-1:0]        src_clk_in,
  input  wire logic [NPIN-1:0]        pulse_pin_in,
  // interrupt request
  output logic                        timer_irq_out
);

  // ***************************************************************
  // address decode
  // ***************************************************************
  function automatic logic lpt_hit(input logic [`LPT_ADDR_W-1:0] addr,
                                   input logic [`LPT_ADDR_W-1:0] off);
    lpt_hit = (addr == off);
  endfunction

  wire logic hit_ctrl_w = lpt_hit(paddr_in, `LPT_OFF_CTRL);
  wire logic hit_psr_w  = lpt_hit(paddr_in, `LPT_OFF_PSR);
  wire logic hit_cmp_w  = lpt_hit(paddr_in, `LPT_OFF_CMP);
  wire logic hit_cnt_w  = lpt_hit(paddr_in, `LPT_OFF_CNT);
  wire logic hit_any_w  = hit_ctrl_w | hit_psr_w | hit_cmp_w | hit_cnt_w;
  wire logic setup_w    = psel_in & ~penable_in;
  wire logic access_w   = psel_in & penable_in;
  wire logic wr_w       = access_w & pwrite_in;
  wire logic wr_ctrl_w  = wr_w & hit_ctrl_w;
  wire logic wr_psr_w   = wr_w & hit_psr_w;
  wire logic wr_cmp_w   = wr_w & hit_cmp_w;

  assign pready_out  = 1'b1;
  assign pslverr_out = access_w & ~hit_any_w;

  // ***************************************************************
  // registers
  // ***************************************************************
  lpt_pkg::lpt_ctrl_t ctrl_reg;
  lpt_pkg::lpt_ctrl_t ctrl_next;
  lpt_pkg::lpt_psr_t  psr_reg;
  lpt_pkg::lpt_psr_t  psr_next;
  logic [CNT_W-1:0]   cmp_reg;
  logic [CNT_W-1:0]   cmp_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;

  // ***************************************************************
  // synchronisers and edge detection
  // ***************************************************************
  logic [NSRC-1:0] src_s1_reg;
  logic [NSRC-1:0] src_s2_reg;
  logic [NSRC-1:0] src_s3_reg;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic            act_prev_reg;
  logic            filt_prev_reg;

  // two flops ahead of edge logic
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
      src_s3_reg <= '0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      src_s1_reg <= src_clk_in;
      src_s2_reg <= src_s1_reg;
      src_s3_reg <= src_s2_reg;
      pin_s1_reg <= pulse_pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire logic [NSRC-1:0] src_rise_w = src_s2_reg & ~src_s3_reg;
  wire logic            clk_rise_w = src_rise_w[psr_reg.clk_sel];
  wire logic            sel_pin_w  = pin_s2_reg[ctrl_reg.pin_sel];
  wire logic            act_w      = sel_pin_w ^ ctrl_reg.pol;
  wire logic            act_rise_w = act_w & ~act_prev_reg;

  // ***************************************************************
  // prescaler and glitch filter
  // ***************************************************************
  wire logic is_time_w  = (ctrl_reg.mode == lpt_pkg::LPT_TIME);
  wire logic presc_run_w = ctrl_reg.en & is_time_w & ~psr_reg.bypass;
  wire logic filt_run_w  = ctrl_reg.en & ~is_time_w & ~psr_reg.bypass;
  logic presc_tick;
  logic filt_level;

  // code drives divider in time mode
  lpt_prescaler #(
    .CW (4),
    .DW (CNT_W)
  ) u_prescaler (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (presc_run_w),
    .tick_in  (clk_rise_w),
    .code_in  (psr_reg.presc),
    .tick_out (presc_tick)
  );

  // code drives filter in pulse mode
  lpt_filter #(
    .CW (4),
    .FW (CNT_W-1)
  ) u_filter (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .run_in    (filt_run_w),
    .tick_in   (clk_rise_w),
    .code_in   (psr_reg.presc),
    .level_in  (act_w),
    .level_out (filt_level)
  );

  wire logic filt_rise_w = filt_level & ~filt_prev_reg;
  wire logic time_tick_w  = psr_reg.bypass ? clk_rise_w : presc_tick;
  wire logic pulse_tick_w = psr_reg.bypass ? act_rise_w : filt_rise_w;
  wire logic cnt_tick_w   = ctrl_reg.en & (is_time_w ? time_tick_w : pulse_tick_w);

  // ***************************************************************
  // counter and compare flag
  // ***************************************************************
  wire logic match_w     = (cnt_reg == cmp_reg);
  wire logic flag_set_w  = cnt_tick_w & match_w;
  wire logic flag_clr_w  = wr_ctrl_w & pwdata_in[`LPT_FLAG_BIT];
  wire lpt_pkg::lpt_ctrl_t wctrl_w = pwdata_in[`LPT_CTRL_W-1:0];

  // clear on match when not free running
  assign cnt_next = !ctrl_reg.en ? '0 :
                    !cnt_tick_w ? cnt_reg :
                    (match_w && !ctrl_reg.free_run) ? '0 : cnt_reg + 1'b1;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl_w)
    begin
      ctrl_next         = wctrl_w;
      ctrl_next.flag    = ctrl_reg.flag;
    end
    ctrl_next.flag = ctrl_reg.en & (flag_set_w | (ctrl_reg.flag & ~flag_clr_w));
  end

  assign psr_next = wr_psr_w ? lpt_pkg::lpt_psr_t'(pwdata_in[`LPT_PSR_W-1:0]) : psr_reg;
  assign cmp_next = wr_cmp_w ? pwdata_in[CNT_W-1:0] : cmp_reg;

  assign rdata_next = !setup_w ? rdata_reg :
                      hit_ctrl_w ? {24'h000000, ctrl_reg} :
                      hit_psr_w  ? {25'h0000000, psr_reg} :
                      hit_cmp_w  ? {{(32-CNT_W){1'b0}}, cmp_reg} :
                      hit_cnt_w  ? {{(32-CNT_W){1'b0}}, cnt_reg} : 32'h00000000;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_reg      <= lpt_pkg::lpt_ctrl_t'(`LPT_CTRL_RST);
      psr_reg       <= lpt_pkg::lpt_psr_t'(`LPT_PSR_RST);
      cmp_reg       <= '0;
      cnt_reg       <= '0;
      rdata_reg     <= 32'h00000000;
      act_prev_reg  <= 1'b0;
      filt_prev_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      psr_reg       <= psr_next;
      cmp_reg       <= cmp_next;
      cnt_reg       <= cnt_next;
      rdata_reg     <= rdata_next;
      act_prev_reg  <= act_w;
      filt_prev_reg <= filt_level;
    end
  end

  assign prdata_out = rdata_reg;
  assign timer_irq_out = ctrl_reg.flag & ctrl_reg.irq_en;

  // ***************************************************************
  // assertions
  // ***************************************************************
  wire logic at_max_w = (cnt_reg == {CNT_W{1'b1}});

  disabled_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_reg.en |=> cnt_reg == '0 && !ctrl_reg.flag)
    else $error("disabled timer left counter or flag set");

  match_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && cnt_tick_w && match_w && !ctrl_reg.free_run
    |=> cnt_reg == '0 && ctrl_reg.flag)
    else $error("match did not clear counter and set flag");

  free_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && cnt_tick_w && ctrl_reg.free_run && at_max_w |=> cnt_reg == '0)
    else $error("free running counter did not wrap");

  free_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && cnt_tick_w && ctrl_reg.free_run && match_w && !at_max_w
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("free running counter cleared on match");

  time_bypass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && is_time_w && psr_reg.bypass && src_rise_w[psr_reg.clk_sel]
    |=> cnt_reg != $past(cnt_reg) || $past(match_w))
    else $error("bypassed time mode missed a source edge");

  pulse_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && !is_time_w && psr_reg.bypass && $rose(act_w) && $stable(ctrl_reg.pol)
    |=> cnt_reg != $past(cnt_reg) || $past(match_w))
    else $error("bypassed pulse mode missed an active edge");

  idle_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && !cnt_tick_w |=> $stable(cnt_reg))
    else $error("counter moved without a tick");

  flag_w1c_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.flag && flag_clr_w && !flag_set_w ##1 ctrl_reg.en |-> !ctrl_reg.flag)
    else $error("write one did not clear flag");

  irq_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.irq_en && $rose(ctrl_reg.flag) |-> timer_irq_out)
    else $error("interrupt missing with flag set");

  psr_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    setup_w && !pwrite_in && hit_psr_w |=> prdata_out[31:7] == 25'h0000000)
    else $error("reserved prescale bits read nonzero");

  irq_raise_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    flag_set_w && ctrl_reg.irq_en && !wr_ctrl_w |=> timer_irq_out)
    else $error("interrupt not raised with new flag");

  parts_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_reg.en |=> !presc_tick && !filt_level)
    else $error("disabled timer left prescaler or filter active");

  flag_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && ctrl_reg.flag && !flag_clr_w |=> ctrl_reg.flag)
    else $error("compare flag dropped without clear");

  flag_cause_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(ctrl_reg.flag) |-> $past(flag_set_w))
    else $error("compare flag set without match");

  presc_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && is_time_w && !psr_reg.bypass && presc_tick
    |=> cnt_reg != $past(cnt_reg) || $past(match_w))
    else $error("prescaled tick did not move counter");

  filt_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && !is_time_w && !psr_reg.bypass && filt_rise_w
    |=> cnt_reg != $past(cnt_reg) || $past(match_w))
    else $error("filtered edge did not move counter");

  psr_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_psr_w |=> psr_reg == $past(pwdata_in[`LPT_PSR_W-1:0]))
    else $error("prescale write not stored");

  src_pick_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && is_time_w && psr_reg.bypass && !src_rise_w[psr_reg.clk_sel]
    |=> $stable(cnt_reg))
    else $error("unselected source moved counter");

  pin_pick_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.en && !is_time_w && psr_reg.bypass && !act_rise_w |=> $stable(cnt_reg))
    else $error("counter moved without selected pin edge");

  flag_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(ctrl_reg.flag));
  wrap_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg.free_run && cnt_tick_w && at_max_w);
  filt_count_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    filt_run_w && filt_rise_w);
  presc_count_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    presc_run_w && presc_tick);
  pin_three_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    !is_time_w && ctrl_reg.pin_sel == `LPT_SEL_THREE && cnt_tick_w);

endmodule
`default_nettype wire

// file: lpt_params.svh
// Purpose : offsets, field positions and reset values of the low power timer
// Assumes : included by bare name wherever a constant is needed
// Notes   : definitions only
`ifndef LPT_PARAMS_SVH
`define LPT_PARAMS_SVH

// ***************************************************************
// register map (byte addresses, 32-bit aligned words)
// ***************************************************************
`define LPT_ADDR_W      12
`define LPT_OFF_CTRL    12'h000
`define LPT_OFF_PSR     12'h004
`define LPT_OFF_CMP     12'h008
`define LPT_OFF_CNT     12'h00c

// ***************************************************************
// field layout and reset values
// ***************************************************************
`define LPT_CTRL_W      8
`define LPT_PSR_W       7
`define LPT_CTRL_RST    8'h00
`define LPT_PSR_RST     7'h00
`define LPT_FLAG_BIT    7
`define LPT_SEL_ONE     2'h1
`define LPT_SEL_TWO     2'h2
`define LPT_SEL_THREE   2'h3

`endif

// file: lpt_pkg.sv
// Purpose : types shared by the low power timer files
// Assumes : fields match the layout in lpt_params.svh
// Notes   : nothing is imported; users write lpt_pkg::name
package lpt_pkg;

  typedef enum logic {LPT_TIME, LPT_PULSE} lpt_mode_t;

  // control and status word, bit 7 down to bit 0
  typedef struct packed {
    logic      flag;
    logic      irq_en;
    logic [1:0] pin_sel;
    logic      pol;
    logic      free_run;
    lpt_mode_t mode;
    logic      en;
  } lpt_ctrl_t;

  // prescale word, bit 6 down to bit 0
  typedef struct packed {
    logic [3:0] presc;
    logic       bypass;
    logic [1:0] clk_sel;
  } lpt_psr_t;

endpackage

// file: lpt_prescaler.sv
// Purpose : divides selected prescaler clock ticks by 2**(code+1)
// Assumes : tick_in is a one-cycle pulse on clk_in per source clock edge
// Notes   : held cleared while run_in is low
`timescale 1ns/1ps
`default_nettype none
module lpt_prescaler #(
  parameter int CW = 4,
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // control
  input  wire logic          run_in,
  input  wire logic          tick_in,
  input  wire logic [CW-1:0] code_in,
  // divided tick
  output logic               tick_out
);

  logic [DW-1:0] cnt_reg;
  logic [DW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;
  wire  logic [DW:0]   span_w = (DW+1)'(1) << ({1'b0, code_in} + (CW+1)'(1));
  wire  logic [DW:0]   term_full_w = span_w - (DW+1)'(1);
  wire  logic [DW-1:0] term_w = term_full_w[DW-1:0];
  wire  logic          at_term_w = (cnt_reg == term_w);

  // divide by two to n plus one
  assign cnt_next  = !run_in ? '0 : !tick_in ? cnt_reg : at_term_w ? '0 : cnt_reg + 1'b1;
  // code zero gives divide by two
  assign tick_next = run_in & tick_in & at_term_w;
  assign tick_out  = tick_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  divide_term_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_out |-> $past(cnt_reg) == $past(term_w) && $past(tick_in))
    else $error("prescaler tick not at terminal count");

endmodule
`default_nettype wire

// file: lpt_filter.sv
// Purpose : glitch filter, a new level passes after 2**code filter ticks
// Assumes : level_in already synchronised to clk_in
// Notes   : code zero is unsupported and behaves as one tick
`timescale 1ns/1ps
`default_nettype none
module lpt_filter #(
  parameter int CW = 4,
  parameter int FW = 15
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // control
  input  wire logic          run_in,
  input  wire logic          tick_in,
  input  wire logic [CW-1:0] code_in,
  // filtered level
  input  wire logic          level_in,
  output logic               level_out
);

  logic [FW-1:0] cnt_reg;
  logic [FW-1:0] cnt_next;
  logic          level_reg;
  logic          level_next;
  wire  logic [FW:0]   need_full_w = ((FW+1)'(1) << code_in) - (FW+1)'(1);
  wire  logic [FW-1:0] need_w = need_full_w[FW-1:0];
  wire  logic          differ_w = (level_in != level_reg);
  wire  logic          accept_w = tick_in & differ_w & (cnt_reg == need_w);

  assign cnt_next   = !run_in || !differ_w || accept_w ? '0 :
                      tick_in ? cnt_reg + 1'b1 : cnt_reg;
  assign level_next = !run_in ? 1'b0 : accept_w ? level_in : level_reg;
  assign level_out  = level_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
    end
  end

  filter_width_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    run_in && $changed(level_out) |-> $past(cnt_reg) == $past(need_w) && $past(tick_in))
    else $error("filter passed change before its width");

endmodule
`default_nettype wire

// file: lpt_pulse_src.sv
// Purpose : pulse source model standing on the counter input pins
// Assumes : runs on clk_in; one burst of num_in pulses per go_in pulse
// Notes   : unselected pins toggle every two cycles to expose bad routing
`timescale 1ns/1ps
`default_nettype none
module lpt_pulse_src (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // burst command
  input  wire logic       go_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       pol_in,
  input  wire logic [7:0] num_in,
  input  wire logic [7:0] wid_in,
  // pins and status
  output logic [3:0]      pins_out,
  output logic            busy_out
);
  logic [7:0] left_reg;
  logic [7:0] ph_reg;
  logic       act_reg;
  logic [1:0] bg_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      left_reg <= 8'h00;
      ph_reg   <= 8'h00;
      act_reg  <= 1'b0;
      bg_reg   <= 2'h0;
    end
    else
    begin
      bg_reg <= bg_reg + 2'h1;
      if (left_reg == 8'h00)
      begin
        act_reg <= 1'b0;
        if (go_in)
        begin
          left_reg <= num_in;
          ph_reg   <= wid_in;
        end
      end
      else if (ph_reg == 8'h00)
      begin
        ph_reg  <= wid_in;
        act_reg <= ~act_reg;
        if (act_reg)
          left_reg <= left_reg - 8'h01;
      end
      else
        ph_reg <= ph_reg - 8'h01;
    end
  end
  // inactive level idles, polarity picks the active level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pins_out[i] = (sel_in == 2'(i)) ? (act_reg ^ pol_in) : bg_reg[1];
  end
  assign busy_out = (left_reg != 8'h00);
endmodule
`default_nettype wire

// file: low_power_timer_control_bench.sv
// Purpose : self-checking bench for lpt_top
// Assumes : zero wait APB slave; source clocks derived from clk_in
// Notes   : counts from async sources are checked within a small window
`timescale 1ns/1ps
`default_nettype none
`include "lpt_params.svh"
module low_power_timer_control_bench;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  div_reg = 6'h00;
  logic [3:0]  pins;
  logic        irq;
  logic        go = 1'b0;
  logic [1:0]  ssel = 2'h1;
  logic        spol = 1'b0;
  logic [7:0]  snum = 8'h05;
  logic [7:0]  swid = 8'h04;
  logic        sbusy;
  int          miscompares = 0;
  int          n_tests = 0;
  // ********************
  // clock, sources, instances
  // ********************
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) div_reg <= div_reg + 6'h01;
  lpt_top i_lpt_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .src_clk_in(div_reg[4:1]), .pulse_pin_in(pins), .timer_irq_out(irq));
  lpt_pulse_src i_lpt_pulse_src (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
    .sel_in(ssel), .pol_in(spol), .num_in(snum), .wid_in(swid), .pins_out(pins),
    .busy_out(sbusy));
  // ********************
  // bus and compare tasks
  // ********************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_in);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if (!(got >= lo && got <= hi) || $isunknown(got))
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic lpt_pkg::lpt_ctrl_t mk(input logic m, input logic fr, input logic pol,
                                            input logic [1:0] s, input logic ie);
    return lpt_pkg::lpt_ctrl_t'({1'b0, ie, s, pol, fr, m, 1'b0});
  endfunction
  // fields change only while disabled, and the enabling write repeats them
  task automatic start(input lpt_pkg::lpt_ctrl_t c, input logic [3:0] code,
                       input logic byp, input logic [1:0] cs);
    wr(`LPT_OFF_CTRL, 32'h0);
    wr(`LPT_OFF_CTRL, 32'(c));
    wr(`LPT_OFF_PSR, 32'({code, byp, cs}));
    c.en = 1'b1;
    wr(`LPT_OFF_CTRL, 32'(c));
  endtask
  task automatic burst();
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
    while (sbusy === 1'b1)
    begin
      @(posedge clk_in);
    end
    repeat (20) @(posedge clk_in);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(`LPT_OFF_CTRL, r);
    chk(r, 32'h0);
    wr(`LPT_OFF_PSR, 32'hffffffff);
    rd(`LPT_OFF_PSR, r);
    chk(r, 32'h0000007f);
    wr(`LPT_OFF_CNT, 32'h00001234);
    rd(`LPT_OFF_CNT, r);
    chk(r, 32'h0);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(`LPT_OFF_PSR, 32'h0);
  endtask
  task automatic t_time();
    logic [31:0] r;
    for (int k = 0; k < 4; k++)
    begin
      start(mk(1'b0, 1'b1, 1'b0, 2'h1, 1'b0), 4'h0, 1'b1, 2'(k));
      repeat (512) @(posedge clk_in);
      rd(`LPT_OFF_CNT, r);
      chk_rng(r, (128 >> k) - 2, (128 >> k) + 2);
    end
  endtask
  task automatic t_presc();
    logic [31:0] r;
    int          codes[3] = '{0, 2, 5};
    for (int i = 0; i < 3; i++)
    begin
      start(mk(1'b0, 1'b1, 1'b0, 2'h1, 1'b0), 4'(codes[i]), 1'b0, 2'h0);
      repeat (512) @(posedge clk_in);
      rd(`LPT_OFF_CNT, r);
      chk_rng(r, (128 >> (codes[i] + 1)) - 1, (128 >> (codes[i] + 1)) + 1);
    end
  endtask
  task automatic t_cmp();
    logic [31:0] r;
    wr(`LPT_OFF_CMP, 32'h3);
    start(mk(1'b0, 1'b0, 1'b0, 2'h1, 1'b1), 4'h0, 1'b1, 2'h0);
    repeat (64) @(posedge clk_in);
    rd(`LPT_OFF_CTRL, r);
    chk({31'h0, r[7]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(`LPT_OFF_CNT, r);
    chk_rng(r, 0, 3);
    start(mk(1'b0, 1'b1, 1'b0, 2'h1, 1'b1), 4'h0, 1'b1, 2'h0);
    repeat (64) @(posedge clk_in);
    rd(`LPT_OFF_CNT, r);
    chk_rng(r, 12, 18);
    rd(`LPT_OFF_CTRL, r);
    chk({31'h0, r[7]}, 32'h1);
    wr(`LPT_OFF_CTRL, 32'h000000d5);
    repeat (8) @(posedge clk_in);
    rd(`LPT_OFF_CTRL, r);
    chk({31'h0, r[7]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`LPT_OFF_CTRL, 32'h00000054);
    rd(`LPT_OFF_CNT, r);
    chk(r, 32'h0);
  endtask
  task automatic t_pulse();
    logic [31:0] r;
    for (int s = 1; s < 4; s++)
      for (int p = 0; p < 2; p++)
      begin
        ssel <= 2'(s);
        spol <= 1'(p);
        swid <= 8'h04;
        start(mk(1'b1, 1'b1, 1'(p), 2'(s), 1'b0), 4'h0, 1'b1, 2'h0);
        burst();
        rd(`LPT_OFF_CNT, r);
        chk(r, 32'h5);
      end
  endtask
  task automatic t_filter();
    logic [31:0] r;
    int          codes[3] = '{1, 4, 4};
    int          wids[3] = '{40, 20, 80};
    int          exps[3] = '{3, 0, 3};
    ssel <= 2'h1;
    spol <= 1'b0;
    snum <= 8'h03;
    for (int i = 0; i < 3; i++)
    begin
      swid <= 8'(wids[i]);
      start(mk(1'b1, 1'b0, 1'b0, 2'h1, 1'b0), 4'(codes[i]), 1'b0, 2'h0);
      burst();
      rd(`LPT_OFF_CNT, r);
      chk(r, 32'(exps[i]));
    end
  endtask
  // ********************
  // sequence and verdict
  // ********************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_time();
    t_presc();
    t_cmp();
    t_pulse();
    t_filter();
    summarize();
  end
  // about 5400 cycles expected; cut off well beyond that
  initial
  begin
    #1000000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
